// file: common/cqs_pkg.sv
// Shared constants for the calibration sequencer debug status block
package cqs_pkg;

    // Bus and datapath widths
    localparam int ADDR_W   = 8;   // Register address width
    localparam int DATA_W   = 32;  // Register data width
    localparam int LANES    = 18;  // Data strobe byte lanes
    localparam int LANE_W   = 6;   // Lane index width
    localparam int WORD_W   = 64;  // Read word per lane
    localparam int CNT_W    = 32;  // Command count width
    localparam int RCNT_W   = 8;   // Read count width
    localparam int MODE_W   = 3;   // Sequence mode width

    // Register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LANE    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CMD_CNT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RD_CNT  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CMD_LFT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_RD_LFT  = 8'h18;

    // Control register fields
    localparam int CTRL_B2B   = 0;  // Back-to-back command mode
    localparam int CTRL_WRLVL = 1;  // Write leveling mode
    localparam int CTRL_PAD   = 2;  // Padded burst mode
    localparam int CTRL_RD    = 3;  // Commands are reads
    localparam int CTRL_START = 4;  // Start pulse, reads as zero
    localparam int CTRL_W     = 4;  // Stored control bits

    // Status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;

    // Sequence mode output fields
    localparam int SEQ_B2B   = 0;
    localparam int SEQ_WRLVL = 1;
    localparam int SEQ_PAD   = 2;

    // Reset values and limits
    localparam logic [CTRL_W-1:0] CTRL_RST  = 4'h0;
    localparam logic [LANE_W-1:0] LANE_RST  = 6'h00;
    localparam logic [LANE_W-1:0] LANE_MAX  = 6'h11;
    localparam logic [CNT_W-1:0]  CNT_RST   = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 32'h0000_0001;
    localparam logic [RCNT_W-1:0] RCNT_RST  = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ISSUE = 2'b01,
        ST_DRAIN = 2'b10
    } cqs_state_t;

endpackage : cqs_pkg

// file: common/cqs_rd_if.sv
`timescale 1ns/10ps
// Lane select out, captured read word back
interface cqs_rd_if;
    logic [cqs_pkg::LANE_W-1:0] lane_sel;   // Requested lane
    logic [cqs_pkg::LANE_W-1:0] lane_tag;   // Lane of the shown word
    logic [cqs_pkg::WORD_W-1:0] word;       // Captured read word
    logic                       word_valid; // Word is newly returned

    modport seq (output lane_sel, input lane_tag, input word, input word_valid);
    modport cap (input lane_sel, output lane_tag, output word, output word_valid);
endinterface : cqs_rd_if

// file: verilog/cqs_rd_capture.sv
`timescale 1ns/10ps
// Picks one lane out of the read FIFO outputs and registers it
module cqs_rd_capture (
    input  wire logic                                       clk,
    input  wire logic                                       rst_n,
    input  wire logic [cqs_pkg::LANES*cqs_pkg::WORD_W-1:0] fifo_data,
    input  wire logic                                       fifo_valid,
    cqs_rd_if.cap                                           rd
);

    logic [cqs_pkg::WORD_W-1:0] word_d;    // Selected lane word
    logic [cqs_pkg::WORD_W-1:0] word_q;
    logic [cqs_pkg::LANE_W-1:0] tag_q;     // Lane the word came from
    logic                       valid_q;   // New word flag

    // Lane mux; codes past the last lane are refused by the writer, so no range hazard
    always_comb begin
        word_d = '0;
        for (int i = 0; i < cqs_pkg::LANES; i++) begin
            if (rd.lane_sel == i[cqs_pkg::LANE_W-1:0]) begin
                word_d = fifo_data[i*cqs_pkg::WORD_W +: cqs_pkg::WORD_W]; // RQ6
            end
        end
    end

    // Word, tag and valid move together so the probe never sees them skewed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_q  <= '0;
            tag_q   <= cqs_pkg::LANE_RST;
            valid_q <= 1'b0;
        end else begin
            word_q  <= word_d;
            tag_q   <= rd.lane_sel;   // RQ5
            valid_q <= fifo_valid;    // RQ7
        end
    end

    assign rd.word       = word_q;
    assign rd.lane_tag   = tag_q;
    assign rd.word_valid = valid_q;

endmodule : cqs_rd_capture

// file: verilog/cqs_seq_debug.sv
`timescale 1ns/10ps
// Operation
// RQ1: Mode bit 0 flags back-to-back commands
// RQ2: Mode bit 2 flags padded bursts
// RQ3: Command count decrements to zero
// RQ4: Read count decrements to zero on returns
// RQ5: Lane select shows binary byte index 0-17
// RQ6: Debug word is the selected lane's data
// RQ7: Read valid marks each newly returned word
module cqs_seq_debug (
    input  wire logic                                       clk,
    input  wire logic                                       rst_n,
    // Register port
    input  wire logic [cqs_pkg::ADDR_W-1:0]                 reg_addr,
    input  wire logic [cqs_pkg::DATA_W-1:0]                 reg_wdata,
    input  wire logic                                       reg_wr,
    input  wire logic                                       reg_rd,
    output logic      [cqs_pkg::DATA_W-1:0]                 reg_rdata,
    // Command issue toward the PHY
    output logic                                            cmd_valid,
    output logic                                            cmd_is_rd,
    input  wire logic                                       cmd_ready,
    // Read FIFO outputs, all lanes side by side
    input  wire logic [cqs_pkg::LANES*cqs_pkg::WORD_W-1:0] fifo_data,
    input  wire logic                                       fifo_valid,
    // Debug probe outputs
    output logic      [cqs_pkg::MODE_W-1:0]                 dbg_seq_mode,
    output logic      [cqs_pkg::CNT_W-1:0]                  dbg_seq_cmd_cnt,
    output logic      [cqs_pkg::RCNT_W-1:0]                 dbg_seq_rd_cnt,
    output logic      [cqs_pkg::LANE_W-1:0]                 dbg_cmp_lane,
    output logic      [cqs_pkg::WORD_W-1:0]                 dbg_rd_word,
    output logic                                            dbg_rd_valid
);

    // Link to the lane capture stage
    cqs_rd_if rd_link ();

    // Software-visible configuration
    logic [cqs_pkg::CTRL_W-1:0] ctrl_d;      // Mode bits for next job
    logic [cqs_pkg::CTRL_W-1:0] ctrl_q;
    logic [cqs_pkg::LANE_W-1:0] lane_d;      // Lane under observation
    logic [cqs_pkg::LANE_W-1:0] lane_q;
    logic [cqs_pkg::CNT_W-1:0]  cmd_cfg_d;   // Programmed command total
    logic [cqs_pkg::CNT_W-1:0]  cmd_cfg_q;
    logic [cqs_pkg::RCNT_W-1:0] rd_cfg_d;    // Programmed read total
    logic [cqs_pkg::RCNT_W-1:0] rd_cfg_q;

    // Sequencer state
    cqs_pkg::cqs_state_t        state_d;
    cqs_pkg::cqs_state_t        state_q;
    logic [cqs_pkg::CNT_W-1:0]  cmd_left_d;  // Commands still to issue
    logic [cqs_pkg::CNT_W-1:0]  cmd_left_q;
    logic [cqs_pkg::RCNT_W-1:0] rd_left_d;   // Reads still to return
    logic [cqs_pkg::RCNT_W-1:0] rd_left_q;
    logic [cqs_pkg::MODE_W-1:0] mode_d;      // Mode of running job
    logic [cqs_pkg::MODE_W-1:0] mode_q;
    logic                       valid_d;     // Command offered
    logic                       valid_q;
    logic                       is_rd_d;     // Offered command is a read
    logic                       is_rd_q;
    logic                       done_d;      // Sticky job finished
    logic                       done_q;

    // Read data register
    logic [cqs_pkg::DATA_W-1:0] rdata_d;
    logic [cqs_pkg::DATA_W-1:0] rdata_q;

    // Decoded strobes
    logic wr_ctrl;
    logic wr_lane;
    logic wr_cmd;
    logic wr_rdc;
    logic wr_stat;
    logic start;
    logic cmd_taken;
    logic job_end;

    // Write decode, one register per aligned word
    always_comb begin
        wr_ctrl = reg_wr && (reg_addr == cqs_pkg::OFS_CTRL);
        wr_lane = reg_wr && (reg_addr == cqs_pkg::OFS_LANE);
        wr_cmd  = reg_wr && (reg_addr == cqs_pkg::OFS_CMD_CNT);
        wr_rdc  = reg_wr && (reg_addr == cqs_pkg::OFS_RD_CNT);
        wr_stat = reg_wr && (reg_addr == cqs_pkg::OFS_STATUS);
        // Start while busy is dropped; a job cannot be restarted midway
        start   = wr_ctrl && reg_wdata[cqs_pkg::CTRL_START]
                  && (state_q == cqs_pkg::ST_IDLE);
        cmd_taken = valid_q && cmd_ready;
    end

    // Configuration next values
    always_comb begin
        ctrl_d    = ctrl_q;
        lane_d    = lane_q;
        cmd_cfg_d = cmd_cfg_q;
        rd_cfg_d  = rd_cfg_q;
        if (wr_ctrl) begin
            ctrl_d = reg_wdata[cqs_pkg::CTRL_W-1:0];
        end
        // Codes past the last lane are refused, old lane stays
        if (wr_lane && (reg_wdata[cqs_pkg::LANE_W-1:0] <= cqs_pkg::LANE_MAX)) begin
            lane_d = reg_wdata[cqs_pkg::LANE_W-1:0];   // RQ5
        end
        if (wr_cmd) begin
            cmd_cfg_d = reg_wdata;
        end
        if (wr_rdc) begin
            rd_cfg_d = reg_wdata[cqs_pkg::RCNT_W-1:0];
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q    <= cqs_pkg::CTRL_RST;
            lane_q    <= cqs_pkg::LANE_RST;
            cmd_cfg_q <= cqs_pkg::CNT_RST;
            rd_cfg_q  <= cqs_pkg::RCNT_RST;
        end else begin
            ctrl_q    <= ctrl_d;
            lane_q    <= lane_d;
            cmd_cfg_q <= cmd_cfg_d;
            rd_cfg_q  <= rd_cfg_d;
        end
    end

    // Sequencer: load counts on start, issue, then wait for reads
    always_comb begin
        state_d    = state_q;
        cmd_left_d = cmd_left_q;
        rd_left_d  = rd_left_q;
        mode_d     = mode_q;
        valid_d    = valid_q;
        is_rd_d    = is_rd_q;
        done_d     = done_q;
        job_end    = 1'b0;
        unique case (state_q)
            cqs_pkg::ST_IDLE: begin
                if (start) begin
                    // Mode is taken from the written word, not the old one
                    mode_d[cqs_pkg::SEQ_B2B]   = reg_wdata[cqs_pkg::CTRL_B2B];   // RQ1
                    mode_d[cqs_pkg::SEQ_WRLVL] = reg_wdata[cqs_pkg::CTRL_WRLVL];
                    mode_d[cqs_pkg::SEQ_PAD]   = reg_wdata[cqs_pkg::CTRL_PAD];   // RQ2
                    is_rd_d = reg_wdata[cqs_pkg::CTRL_RD];
                    // Single mode issues exactly one command
                    cmd_left_d = reg_wdata[cqs_pkg::CTRL_B2B] ? cmd_cfg_q
                                                             : cqs_pkg::CNT_ONE; // RQ1
                    // Reads are only expected for read commands
                    rd_left_d = reg_wdata[cqs_pkg::CTRL_RD] ? rd_cfg_q
                                                           : cqs_pkg::RCNT_RST;  // RQ4
                    done_d = 1'b0;
                    if (cmd_left_d == cqs_pkg::CNT_RST) begin
                        state_d = cqs_pkg::ST_DRAIN;
                    end else begin
                        valid_d = 1'b1;
                        state_d = cqs_pkg::ST_ISSUE;
                    end
                end
            end
            cqs_pkg::ST_ISSUE: begin
                if (cmd_taken) begin
                    cmd_left_d = cmd_left_q - cqs_pkg::CNT_ONE;   // RQ3
                    // Last command out: stop offering
                    if (cmd_left_q == cqs_pkg::CNT_ONE) begin
                        valid_d = 1'b0;
                        state_d = cqs_pkg::ST_DRAIN;
                    end
                end
            end
            cqs_pkg::ST_DRAIN: begin
                // A return in this same cycle is allowed for here; rd_left_q is only stepped below
                if ((rd_left_q == cqs_pkg::RCNT_RST)
                    || ((rd_left_q == 8'h01) && fifo_valid)) begin
                    job_end = 1'b1;
                    state_d = cqs_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = cqs_pkg::ST_IDLE;
                valid_d = 1'b0;
            end
        endcase
        // Returns count down while a job runs; extra returns saturate at zero
        if ((state_q != cqs_pkg::ST_IDLE) && fifo_valid
            && (rd_left_q != cqs_pkg::RCNT_RST)) begin
            rd_left_d = rd_left_q - 8'h01;   // RQ4
        end
        // Software clears done by writing one; a finish in that cycle wins
        if (wr_stat && reg_wdata[cqs_pkg::STAT_DONE]) begin
            done_d = 1'b0;
        end
        if (job_end) begin
            done_d = 1'b1;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= cqs_pkg::ST_IDLE;
            cmd_left_q <= cqs_pkg::CNT_RST;
            rd_left_q  <= cqs_pkg::RCNT_RST;
            mode_q     <= 3'h0;
            valid_q    <= 1'b0;
            is_rd_q    <= 1'b0;
            done_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            cmd_left_q <= cmd_left_d;
            rd_left_q  <= rd_left_d;
            mode_q     <= mode_d;
            valid_q    <= valid_d;
            is_rd_q    <= is_rd_d;
            done_q     <= done_d;
        end
    end

    // Read mux; data only in the cycle after the strobe, zero otherwise
    always_comb begin
        rdata_d = cqs_pkg::DATA_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                cqs_pkg::OFS_CTRL: begin
                    rdata_d[cqs_pkg::CTRL_W-1:0] = ctrl_q;
                end
                cqs_pkg::OFS_LANE: begin
                    rdata_d[cqs_pkg::LANE_W-1:0] = lane_q;
                end
                cqs_pkg::OFS_CMD_CNT: begin
                    rdata_d = cmd_cfg_q;
                end
                cqs_pkg::OFS_RD_CNT: begin
                    rdata_d[cqs_pkg::RCNT_W-1:0] = rd_cfg_q;
                end
                cqs_pkg::OFS_STATUS: begin
                    rdata_d[cqs_pkg::STAT_BUSY] = (state_q != cqs_pkg::ST_IDLE);
                    rdata_d[cqs_pkg::STAT_DONE] = done_q;
                end
                cqs_pkg::OFS_CMD_LFT: begin
                    rdata_d = cmd_left_q;
                end
                cqs_pkg::OFS_RD_LFT: begin
                    rdata_d[cqs_pkg::RCNT_W-1:0] = rd_left_q;
                end
                // Unmapped offsets read as zero
                default: begin
                    rdata_d = cqs_pkg::DATA_ZERO;
                end
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= cqs_pkg::DATA_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Lane capture, one register stage after the FIFOs
    assign rd_link.lane_sel = lane_q;

    cqs_rd_capture u_capture (
        .clk        (clk),
        .rst_n      (rst_n),
        .fifo_data  (fifo_data),
        .fifo_valid (fifo_valid),
        .rd         (rd_link.cap)
    );

    // Outputs, all straight from flip-flops
    assign reg_rdata       = rdata_q;
    assign cmd_valid       = valid_q;
    assign cmd_is_rd       = is_rd_q;
    assign dbg_seq_mode    = mode_q;               // RQ1
    assign dbg_seq_cmd_cnt = cmd_left_q;           // RQ3
    assign dbg_seq_rd_cnt  = rd_left_q;            // RQ4
    assign dbg_cmp_lane    = rd_link.lane_tag;     // RQ5
    assign dbg_rd_word     = rd_link.word;         // RQ6
    assign dbg_rd_valid    = rd_link.word_valid;   // RQ7

endmodule : cqs_seq_debug

// file: testbench/cqs_seq_debug_chk.sv
`timescale 1ns/10ps
// Timing relations on the debug probe outputs
module cqs_seq_debug_chk (
    input wire logic                                      clk,
    input wire logic                                      rst_n,
    input wire logic [cqs_pkg::ADDR_W-1:0]                reg_addr,
    input wire logic [cqs_pkg::DATA_W-1:0]                reg_wdata,
    input wire logic                                      reg_wr,
    input wire logic                                      cmd_valid,
    input wire logic                                      cmd_ready,
    input wire logic [cqs_pkg::LANES*cqs_pkg::WORD_W-1:0] fifo_data,
    input wire logic                                      fifo_valid,
    input wire logic [cqs_pkg::MODE_W-1:0]                dbg_seq_mode,
    input wire logic [cqs_pkg::CNT_W-1:0]                 dbg_seq_cmd_cnt,
    input wire logic [cqs_pkg::RCNT_W-1:0]                dbg_seq_rd_cnt,
    input wire logic [cqs_pkg::LANE_W-1:0]                dbg_cmp_lane,
    input wire logic [cqs_pkg::WORD_W-1:0]                dbg_rd_word,
    input wire logic                                      dbg_rd_valid
);
    // Last cycle's FIFO lanes, the source of the shown word
    logic [cqs_pkg::LANES*cqs_pkg::WORD_W-1:0] fifo_q;

    // Plain capture register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_q <= '0;
        end else begin
            fifo_q <= fifo_data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_valid_rise:
    assert property (fifo_valid |=> dbg_rd_valid) else $error("return without read valid");
    a_valid_fall:
    assert property (!fifo_valid |=> !dbg_rd_valid) else $error("read valid without return");
    a_word_lane:
    assert property (dbg_cmp_lane <= cqs_pkg::LANE_MAX |->
        dbg_rd_word == fifo_q[dbg_cmp_lane*cqs_pkg::WORD_W +: cqs_pkg::WORD_W])
        else $error("debug word is not the shown lane");
    a_lane_range:
    assert property (dbg_cmp_lane <= cqs_pkg::LANE_MAX) else $error("lane code above 17");
    a_lane_follow:
    assert property (reg_wr && reg_addr == cqs_pkg::OFS_LANE && reg_wdata < 32'h0000_0012
        |=> ##1 dbg_cmp_lane == $past(reg_wdata[5:0], 2)) else $error("lane not shown");
    a_cnt_step:
    assert property (cmd_valid && cmd_ready |=> dbg_seq_cmd_cnt == $past(dbg_seq_cmd_cnt) - 1)
        else $error("command count did not step");
    a_cnt_last:
    assert property (cmd_valid && cmd_ready && dbg_seq_cmd_cnt == cqs_pkg::CNT_ONE
        |=> !cmd_valid && dbg_seq_cmd_cnt == cqs_pkg::CNT_RST) else $error("last command");
    a_rcnt_step:
    assert property (fifo_valid && dbg_seq_rd_cnt != 8'h00
        |=> dbg_seq_rd_cnt == $past(dbg_seq_rd_cnt) - 8'h01) else $error("read count step");
    a_rcnt_floor:
    assert property (dbg_seq_rd_cnt == 8'h00 && !reg_wr |=> dbg_seq_rd_cnt == 8'h00)
        else $error("read count left zero");
    a_mode_hold:
    assert property (!(reg_wr && reg_addr == cqs_pkg::OFS_CTRL) |=> $stable(dbg_seq_mode))
        else $error("mode moved without a control write");
endmodule : cqs_seq_debug_chk

// file: testbench/cqs_phy_model.sv
`timescale 1ns/10ps
// PHY stand-in: takes commands, returns one word per read command
module cqs_phy_model #(
    parameter int LAT = 3 // Read return latency in cycles
) (
    input  wire logic                                      clk,
    input  wire logic                                      rst_n,
    input  wire logic                                      cmd_valid,
    input  wire logic                                      cmd_is_rd,
    input  wire logic                                      slow,
    output logic                                           cmd_ready,
    output logic                                           fifo_valid,
    output logic [cqs_pkg::LANES*cqs_pkg::WORD_W-1:0]      fifo_data
);
    logic [7:0]     cyc_q;  // Free-running cycle count
    logic [LAT-1:0] pend_q; // Read returns in flight

    // Slow mode stalls half the time, so back-to-back issue must wait
    assign cmd_ready  = !slow || cyc_q[1];
    assign fifo_valid = pend_q[LAT-1];

    // Count cycles and delay accepted reads
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_q  <= 8'h00;
            pend_q <= '0;
        end else begin
            cyc_q  <= cyc_q + 8'h01;
            pend_q <= {pend_q[LAT-2:0], cmd_valid && cmd_ready && cmd_is_rd};
        end
    end

    // Every lane differs and changes each cycle, so a stale pick shows
    always_comb begin
        for (int i = 0; i < cqs_pkg::LANES; i++) begin
            fifo_data[i*cqs_pkg::WORD_W +: cqs_pkg::WORD_W] = {8'(i), 48'h5A5A_0000_C3C3, cyc_q};
        end
    end
endmodule : cqs_phy_model

// file: testbench/test_cqs_seq_debug.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module test_cqs_seq_debug;
    logic                                      clk, rst_n, reg_wr, reg_rd, slow, peek, rd_seen;
    logic                                      cmd_valid, cmd_is_rd, cmd_ready;
    logic                                      fifo_valid, dbg_rd_valid, cv_q;
    logic [7:0]                                reg_addr;
    logic [31:0]                               reg_wdata, reg_rdata, seed, n;
    logic [cqs_pkg::LANES*cqs_pkg::WORD_W-1:0] fifo_data;
    logic [2:0]                                dbg_seq_mode;
    logic [31:0]                               dbg_seq_cmd_cnt;
    logic [7:0]                                dbg_seq_rd_cnt;
    logic [5:0]                                dbg_cmp_lane, lane;
    logic [63:0]                               dbg_rd_word;
    logic [69:0]                               e;
    logic [31:0]                               rq[$]; // Expected read data
    logic [69:0]                               wq[$]; // Expected lane and word
    logic [2:0]                                mq[$]; // Expected mode
    logic [40:0]                               lq[$]; // Expected kind and loaded counts
    int                                        failures, checks;

    cqs_seq_debug cqs_seq_debug_i (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cmd_valid, .cmd_is_rd, .cmd_ready, .fifo_data, .fifo_valid, .dbg_seq_mode,
        .dbg_seq_cmd_cnt, .dbg_seq_rd_cnt, .dbg_cmp_lane, .dbg_rd_word, .dbg_rd_valid);
    cqs_phy_model cqs_phy_model_i (.clk, .rst_n, .cmd_valid, .cmd_is_rd, .slow, .cmd_ready,
        .fifo_valid, .fifo_data);

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Result watcher: oldest note against what appears
    always @(posedge clk) begin
        if (rd_seen) begin
            e = 70'(rq.pop_front());
            `CHK("reg_rdata", e[31:0], reg_rdata)
        end
        if (dbg_rd_valid) begin
            e = wq.pop_front();
            `CHK("lane_word", e, {dbg_cmp_lane, dbg_rd_word})
        end
        // Pop once; the macro repeats its expected operand
        if (peek) begin
            e = 70'(mq.pop_front());
            `CHK("seq_mode", e[2:0], dbg_seq_mode)
        end
        // Counts as loaded, seen when the first command is offered
        if (cmd_valid && !cv_q) begin
            e = 70'(lq.pop_front());
            `CHK("counts", e[40:0], {cmd_is_rd, dbg_seq_cmd_cnt, dbg_seq_rd_cnt})
        end
        if (fifo_valid && rst_n) begin
            wq.push_back({lane, fifo_data[lane*cqs_pkg::WORD_W +: cqs_pkg::WORD_W]});
        end
        rd_seen <= reg_rd;
        cv_q    <= cmd_valid;
    end

    // Bus cycles; each task lowers the other strobe, idle lowers both
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        rq.push_back(x);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        @(posedge clk);
    endtask : rd

    task automatic idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask : idle

    // One calibration job; a second start while busy must be refused
    task automatic job(input logic [3:0] c, input logic [5:0] ln, input logic s);
        logic [31:0] r; // Reads expected back
        n = ($random(seed) & 32'h0000_0007) + 32'h0000_0001;
        r = c[3] ? (c[0] ? n : 32'h0000_0001) : 32'h0000_0000;
        wr(cqs_pkg::OFS_LANE, 32'(ln));
        if (ln <= cqs_pkg::LANE_MAX) lane = ln;
        wr(cqs_pkg::OFS_CMD_CNT, n);
        wr(cqs_pkg::OFS_RD_CNT, r);
        slow <= s;
        lq.push_back({c[3], (c[0] ? n : 32'h0000_0001), r[7:0]});
        wr(cqs_pkg::OFS_CTRL, {27'h0, 1'b1, c});
        peek <= 1'b1;
        mq.push_back(c[2:0]);
        wr(cqs_pkg::OFS_CTRL, {27'h0, 1'b1, ~c});
        mq.push_back(c[2:0]);
        idle();
        peek <= 1'b0;
        for (int t = 0; t < 300; t++) begin
            @(negedge clk);
            if (!cmd_valid && dbg_seq_cmd_cnt == 32'h0 && dbg_seq_rd_cnt == 8'h00) break;
        end
        repeat (2) @(posedge clk);
        rd(cqs_pkg::OFS_STATUS, 32'h0000_0002);
        rd(cqs_pkg::OFS_CMD_LFT, 32'h0000_0000);
        rd(cqs_pkg::OFS_RD_LFT, 32'h0000_0000);
        // Refused start still stores its mode bits; start bit reads zero
        rd(cqs_pkg::OFS_CTRL, {28'h000_0000, ~c});
        rd(cqs_pkg::OFS_LANE, 32'(lane));
        rd(cqs_pkg::OFS_CMD_CNT, n);
        rd(cqs_pkg::OFS_RD_CNT, r);
        idle();
    endtask : job

    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test();
    end

    // Main sequence: every lane 0-17 plus codes past the last lane, every mode bit, fast and stalling PHY
    initial begin
        static logic [3:0] tab[6] = '{4'h9, 4'h8, 4'hD, 4'h5, 4'h2, 4'hB};
        seed = 32'h0001_660C;
        {rst_n, reg_wr, reg_rd, slow, peek} = 5'h00;
        {reg_addr, reg_wdata, lane} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'hFC, 32'h0000_0000);
        rd(cqs_pkg::OFS_CMD_LFT, 32'h0000_0000);
        for (int i = 0; i < 26; i++) begin
            job(tab[i % 6], (i < 18) ? 6'(i) : ((i == 18) ? 6'h12 : 6'($random(seed))), i[0]);
        end
        wr(cqs_pkg::OFS_STATUS, 32'h0000_0002);
        rd(cqs_pkg::OFS_STATUS, 32'h0000_0000);
        idle();
        repeat (4) @(posedge clk);
        `CHK("returns_left", 32'h0000_0000, 32'(wq.size()))
        stop_test();
    end
endmodule : test_cqs_seq_debug

bind cqs_seq_debug cqs_seq_debug_chk cqs_seq_debug_chk_i (.clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .cmd_valid, .cmd_ready, .fifo_data, .fifo_valid, .dbg_seq_mode, .dbg_seq_cmd_cnt,
    .dbg_seq_rd_cnt, .dbg_cmp_lane, .dbg_rd_word, .dbg_rd_valid);
